// ---- logic/cgr_pkg.sv ----
// Constants, register map and state codes of the charge and input current setting block.
// Assumes a single 125 MHz system clock.
package cgr_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int          CLK_MHZ       = 125;
  localparam int          TICK_US       = 1000;
  localparam int          TICK_CYC_INT  = TICK_US * CLK_MHZ;
  localparam logic [16:0] TICK_CYCLES   = 17'(TICK_CYC_INT);
  localparam logic [17:0] WDOG_MS       = 18'd175000;
  localparam logic [4:0]  SCL_LOW_MS    = 5'd25;

  // ****************************************************************
  // Bus address and register map
  // ****************************************************************
  localparam logic [6:0]  SLAVE_ADDR    = 7'h09;
  localparam logic [7:0]  CMD_CHARGE    = 8'h14;
  localparam logic [7:0]  CMD_INLIMIT   = 8'h3f;
  localparam logic [15:0] CHARGE_RESET  = 16'h0000;
  localparam logic [15:0] INLIMIT_RESET = 16'h0080;

  // ****************************************************************
  // Code field and limits
  // ****************************************************************
  localparam int          CODE_LSB      = 7;
  localparam int          CODE_W        = 6;
  localparam logic [15:0] CHARGE_MAX    = 16'h1f80;
  localparam logic [15:0] INLIMIT_MAX   = 16'h157e;
  localparam logic [15:0] CHARGE_EN_MIN = 16'h007f;
  localparam logic [5:0]  FOLDBACK_CODE = 6'h01;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } cgr_state_t;

endpackage : cgr_pkg

// ---- logic/cgr_dac_if.sv ----
// Carrier between a setting register and its code decoder.
// Assumes the register side drives the word and reads back the code.
`timescale 1ns/100ps
`default_nettype none
interface cgr_dac_if;
  logic [15:0] word;
  logic [5:0]  code;
  modport src (output word, input code);
  modport dec (input word, output code);
endinterface : cgr_dac_if
`default_nettype wire

// ---- logic/cgr_dac_decode.sv ----
// Turns a stored 16-bit setting word into a 6-bit code with clamping.
// Assumes the word is held stable by a register.
`timescale 1ns/100ps
`default_nettype none
module cgr_dac_decode
  import cgr_pkg::*;
#(
  parameter logic [15:0] LIMIT = CHARGE_MAX
)
(
  cgr_dac_if.dec dac
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Words below one step fall to zero by bit selection alone
  always_comb
  begin
    if (dac.word > LIMIT)
    begin
      dac.code = LIMIT[CODE_LSB +: CODE_W];
    end
    else
    begin
      dac.code = dac.word[CODE_LSB +: CODE_W];
    end
  end

endmodule : cgr_dac_decode
`default_nettype wire

// ---- logic/cgr_regs.sv ----
// Charge current and input limit setting registers behind an SMBus slave port.
// Assumes SCL and SDA are already synchronous to sys_clk_in; SDA wire is resolved outside.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Charge code is word bits 12..7; low seven bits dropped.
// - Charge code bits weigh 128 mA up to 4096 mA, 8064 mA max.
// - One charge register unit is 1 mA with nominal sense resistor.
// - Charge requests above 8.064 A give all-ones code.
// - Charge requests below 128 mA give zero current.
// - Charge register resets to zero; charger disabled until valid writes.
// - Writing zero to charge current stops charging.
// - Charge current register sits at command 0x14.
// - Charge register reads back its stored word.
// - Low battery forces charge code to the 128 mA step.
// - Foldback keeps register intact; releases above 2.7 V.
// - Input limit register sits at command 0x3F.
// - Input limit code is word bits 12..7.
// - Input limit bits weigh 256 mA up to 8192 mA, 11004 mA max.
// - Input limit requests above 11.004 A clamp to maximum.
// - Input limit requests below 256 mA give zero.
// - Input limit register resets to 0x0080.
// - Input limit register reads back its stored word.
// - Only slave address 0b0001001 is answered.
// - Words travel low byte first, high byte second.
// - Charging ends after 175 s without write or 25 ms SCL low.
// - Charging enabled only if current above 0x007F and voltage valid.
module cgr_regs
  import cgr_pkg::*;
#(
  parameter logic [16:0] TICK_CYC = TICK_CYCLES
)
(
  input  wire logic             sys_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  input  wire logic             batt_under_2v5_in,
  input  wire logic             batt_over_2v7_in,
  input  wire logic             charge_voltage_ok_in,
  input  wire logic             charge_voltage_write_in,
  output logic                  sda_out,
  output logic                  sda_oe_out,
  output logic [CODE_W-1:0]     charge_dac_code_out,
  output logic [CODE_W-1:0]     input_limit_dac_code_out,
  output logic                  charge_enable_out,
  output logic                  timeout_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    cgr_state_t  st;
    logic        scl_p;
    logic        sda_p;
    logic [3:0]  bitcnt;
    logic [7:0]  shreg;
    logic [1:0]  idx;
    logic        rw;
    logic        ack;
    logic        commit;
    logic [7:0]  cmd;
    logic [7:0]  lo;
    logic [15:0] chg;
    logic [15:0] inl;
    logic [15:0] txd;
    logic        sda_oe;
    logic [16:0] tick;
    logic [17:0] wdog;
    logic [4:0]  scl_low;
    logic        tmo;
    logic        ovr;
    logic        en;
    logic [5:0]  chg_code;
    logic [5:0]  inl_code;
  } cgr_regs_t;

  cgr_regs_t   r_r;
  cgr_regs_t   r_nxt;
  logic        start_c;
  logic        stop_c;
  logic        rise_c;
  logic        fall_c;
  logic        ms_c;
  logic        wr_c;
  logic        cmd_ok_c;

  cgr_dac_if chg_if ();
  cgr_dac_if inl_if ();

  assign chg_if.word = r_r.chg;
  assign inl_if.word = r_r.inl;

  cgr_dac_decode #(.LIMIT(CHARGE_MAX)) u_chg_dec
  (
    .dac (chg_if)
  );

  cgr_dac_decode #(.LIMIT(INLIMIT_MAX)) u_inl_dec
  (
    .dac (inl_if)
  );

  // ****************************************************************
  // Bus edge detection
  // ****************************************************************
  assign start_c  = r_r.scl_p & scl_in & r_r.sda_p & ~sda_in;
  assign stop_c   = r_r.scl_p & scl_in & ~r_r.sda_p & sda_in;
  assign rise_c   = ~r_r.scl_p & scl_in;
  assign fall_c   = r_r.scl_p & ~scl_in;
  assign ms_c     = (r_r.tick == TICK_CYC - 17'h1);
  assign cmd_ok_c = (r_r.shreg == CMD_CHARGE) || (r_r.shreg == CMD_INLIMIT);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    r_nxt       = r_r;
    wr_c        = 1'b0;
    r_nxt.scl_p = scl_in;
    r_nxt.sda_p = sda_in;

    if (start_c)
    begin
      // Repeated start lands here too and restarts the transfer
      r_nxt.st     = ST_RX;
      r_nxt.bitcnt = 4'h0;
      r_nxt.idx    = 2'h0;
      r_nxt.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      r_nxt.st     = ST_IDLE;
      r_nxt.sda_oe = 1'b0;
    end
    else
    begin
      unique case (r_r.st)
        ST_IDLE:
        begin
          r_nxt.sda_oe = 1'b0;
        end
        ST_RX:
        begin
          if (rise_c)
          begin
            r_nxt.shreg  = {r_r.shreg[6:0], sda_in};
            r_nxt.bitcnt = r_r.bitcnt + 4'h1;
          end
          else if (fall_c && r_r.bitcnt == 4'h8)
          begin
            r_nxt.st     = ST_ACK;
            r_nxt.commit = 1'b0;
            r_nxt.ack    = 1'b1;
            unique case (r_r.idx)
              2'h0:
              begin
                r_nxt.ack = (r_r.shreg[7:1] == SLAVE_ADDR);
                r_nxt.rw  = r_r.shreg[0];
              end
              2'h1:
              begin
                // Unmapped commands are refused so the host sees a clear failure
                r_nxt.ack = cmd_ok_c;
                r_nxt.cmd = r_r.shreg;
              end
              2'h2:
              begin
                r_nxt.lo = r_r.shreg;
              end
              2'h3:
              begin
                r_nxt.commit = 1'b1;
              end
            endcase
            if (!r_nxt.ack)
            begin
              r_nxt.st = ST_IDLE;
            end
            r_nxt.sda_oe = r_nxt.ack;
          end
        end
        ST_ACK:
        begin
          if (fall_c)
          begin
            r_nxt.sda_oe = 1'b0;
            r_nxt.bitcnt = 4'h0;
            r_nxt.st     = ST_RX;
            r_nxt.idx    = r_r.idx + 2'h1;
            if (r_r.commit)
            begin
              // Whole word is kept; only the codes are clamped
              wr_c = 1'b1;
              // A third data byte is refused: one register per transfer
              r_nxt.st = ST_IDLE;
              if (r_r.cmd == CMD_CHARGE)
              begin
                r_nxt.chg = {r_r.shreg, r_r.lo};
              end
              else
              begin
                r_nxt.inl = {r_r.shreg, r_r.lo};
              end
            end
            else if (r_r.idx == 2'h0 && r_r.rw)
            begin
              r_nxt.txd    = (r_r.cmd == CMD_CHARGE) ? r_r.chg : r_r.inl;
              r_nxt.idx    = 2'h0;
              r_nxt.st     = ST_TX;
              r_nxt.sda_oe = (r_r.cmd == CMD_CHARGE) ? ~r_r.chg[7] : ~r_r.inl[7];
            end
          end
        end
        ST_TX:
        begin
          if (fall_c)
          begin
            r_nxt.bitcnt = r_r.bitcnt + 4'h1;
            if (r_r.bitcnt == 4'h7)
            begin
              r_nxt.sda_oe = 1'b0;
              r_nxt.st     = ST_MACK;
            end
            else
            begin
              r_nxt.txd[7:0] = {r_r.txd[6:0], 1'b0};
              r_nxt.sda_oe   = ~r_r.txd[6];
            end
          end
        end
        ST_MACK:
        begin
          if (rise_c)
          begin
            r_nxt.ack = ~sda_in;
          end
          else if (fall_c)
          begin
            r_nxt.bitcnt = 4'h0;
            if (r_r.ack && r_r.idx == 2'h0)
            begin
              // Low byte done, high byte follows
              r_nxt.idx      = 2'h1;
              r_nxt.txd[7:0] = r_r.txd[15:8];
              r_nxt.sda_oe   = ~r_r.txd[15];
              r_nxt.st       = ST_TX;
            end
            else
            begin
              r_nxt.st = ST_IDLE;
            end
          end
        end
        default:
        begin
          r_nxt.st     = ST_IDLE;
          r_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // ****************************************************************
    // Timers
    // ****************************************************************
    r_nxt.tick = ms_c ? 17'h0 : r_r.tick + 17'h1;
    wr_c       = wr_c | charge_voltage_write_in;
    if (wr_c)
    begin
      r_nxt.wdog = 18'h0;
    end
    else if (ms_c && r_r.wdog != WDOG_MS)
    begin
      r_nxt.wdog = r_r.wdog + 18'h1;
    end
    if (scl_in)
    begin
      r_nxt.scl_low = 5'h0;
    end
    else if (ms_c && r_r.scl_low != SCL_LOW_MS)
    begin
      r_nxt.scl_low = r_r.scl_low + 5'h1;
    end
    // Expiry wins over a write landing in the same cycle
    r_nxt.tmo = (r_r.wdog == WDOG_MS) | (r_r.scl_low == SCL_LOW_MS) | (r_r.tmo & ~wr_c);

    // ****************************************************************
    // Foldback and enable
    // ****************************************************************
    if (batt_under_2v5_in)
    begin
      r_nxt.ovr = 1'b1;
    end
    else if (batt_over_2v7_in)
    begin
      r_nxt.ovr = 1'b0;
    end
    r_nxt.en = (r_r.chg > CHARGE_EN_MIN) & charge_voltage_ok_in & ~r_r.tmo;
    if (!r_nxt.en)
    begin
      r_nxt.chg_code = 6'h00;
    end
    else if (r_nxt.ovr)
    begin
      r_nxt.chg_code = FOLDBACK_CODE;
    end
    else
    begin
      r_nxt.chg_code = chg_if.code;
    end
    r_nxt.inl_code = inl_if.code;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      r_r          <= '0;
      r_r.st       <= ST_IDLE;
      r_r.scl_p    <= 1'b1;
      r_r.sda_p    <= 1'b1;
      r_r.chg      <= CHARGE_RESET;
      r_r.inl      <= INLIMIT_RESET;
      r_r.inl_code <= INLIMIT_RESET[CODE_LSB +: CODE_W];
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  assign sda_out                  = 1'b0;
  assign sda_oe_out               = r_r.sda_oe;
  assign charge_dac_code_out      = r_r.chg_code;
  assign input_limit_dac_code_out = r_r.inl_code;
  assign charge_enable_out        = r_r.en;
  assign timeout_out              = r_r.tmo;

endmodule : cgr_regs
`default_nettype wire

// ---- verification/cgr_regs_monitor.sv ----
// Port checker for the charge and input limit setting block.
// Assumes it is bound onto cgr_regs with the same tick parameter.
`timescale 1ns/100ps
`default_nettype none
module cgr_regs_monitor
  import cgr_pkg::*;
#(
  parameter logic [16:0] TICK_CYC = TICK_CYCLES
)
(
  input wire logic              sys_clk_in,
  input wire logic              reset_n_in,
  input wire logic              scl_in,
  input wire logic              sda_in,
  input wire logic              batt_under_2v5_in,
  input wire logic              batt_over_2v7_in,
  input wire logic              charge_voltage_ok_in,
  input wire logic              sda_oe_out,
  input wire logic [CODE_W-1:0] charge_dac_code_out,
  input wire logic [CODE_W-1:0] input_limit_dac_code_out,
  input wire logic              charge_enable_out,
  input wire logic              timeout_out
);
  // ****
  // Checks
  // ****
  logic [31:0] low_cnt_r;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // Saturates so a parked bus never wraps back to a small count
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
    if (!reset_n_in)
      low_cnt_r <= 32'h0;
    else if (scl_in)
      low_cnt_r <= 32'h0;
    else if (low_cnt_r != 32'hffffffff)
      low_cnt_r <= low_cnt_r + 32'h1;

  chk_reset_state: assert property ($rose(reset_n_in) |-> !charge_enable_out &&
    charge_dac_code_out == 6'h00 && input_limit_dac_code_out == 6'h01) else $error("Bad state after reset");
  chk_input_ceiling: assert property (input_limit_dac_code_out <= 6'h2a)
    else $error("Input code above clamp");
  chk_volt_gate: assert property (!charge_voltage_ok_in [*2] |=> !charge_enable_out)
    else $error("Enabled without valid voltage");
  chk_off_zero: assert property (!charge_enable_out [*2] |-> charge_dac_code_out == 6'h00)
    else $error("Charge code live while disabled");
  chk_fold_force: assert property ((batt_under_2v5_in && charge_enable_out) [*4] |->
    charge_dac_code_out == FOLDBACK_CODE) else $error("No foldback code");
  chk_fold_hold: assert property ($fell(batt_under_2v5_in) && !batt_over_2v7_in && charge_enable_out
    |=> !charge_enable_out || charge_dac_code_out == FOLDBACK_CODE) else $error("Foldback left early");
  chk_oe_scl_low: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("Data drive changed with SCL high");
  chk_stop_free: assert property (scl_in && $rose(sda_in) |=> !sda_oe_out [*3])
    else $error("Data driven after stop");
  chk_tmo_off: assert property (timeout_out [*3] |-> !charge_enable_out)
    else $error("Enabled during timeout");
  chk_scl_trip: assert property (low_cnt_r == 28 * TICK_CYC |-> timeout_out)
    else $error("No timeout on long SCL low");
endmodule : cgr_regs_monitor
bind cgr_regs cgr_regs_monitor #(.TICK_CYC(TICK_CYC)) i_cgr_regs_monitor (.*);
`default_nettype wire

// ---- verification/cgr_host_model.sv ----
// SMBus host model for the setting block, bit-banged on the system clock.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module cgr_host_model
#(
  parameter logic [6:0] ADDR = 7'h09
)
(
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  // ****
  // Bus cycles
  // ****
  logic r;
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wt
  // Data moves only while SCL is low; sampled at the end of the high phase
  task automatic bit_x(input logic b, output logic q);
    @(posedge clk_in);
    sda_out <= b;
    wt(4);
    scl_out <= 1'b1;
    wt(4);
    q = sda_in;
    scl_out <= 1'b0;
  endtask : bit_x
  task automatic start();
    @(posedge clk_in);
    sda_out <= 1'b1;
    wt(2);
    scl_out <= 1'b1;
    wt(4);
    sda_out <= 1'b0;
    wt(4);
    scl_out <= 1'b0;
  endtask : start
  task automatic stop();
    @(posedge clk_in);
    sda_out <= 1'b0;
    wt(2);
    scl_out <= 1'b1;
    wt(4);
    sda_out <= 1'b1;
    wt(4);
  endtask : stop
  task automatic wbyte(input logic [7:0] v, inout logic ok);
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, r);
    ok &= !r;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] v, input logic last);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(last, r);
  endtask : rbyte
  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w, output logic ok);
    ok = 1'b1;
    start();
    wbyte({a, 1'b0}, ok);
    wbyte(c, ok);
    wbyte(w[7:0], ok);
    wbyte(w[15:8], ok);
    stop();
  endtask : write_word
  task automatic read_word(input logic [7:0] c, output logic [15:0] w, output logic ok);
    ok = 1'b1;
    start();
    wbyte({ADDR, 1'b0}, ok);
    wbyte(c, ok);
    start();
    wbyte({ADDR, 1'b1}, ok);
    rbyte(w[7:0], 1'b0);
    rbyte(w[15:8], 1'b1);
    stop();
  endtask : read_word
  task automatic hold_low(input int n);
    @(posedge clk_in);
    scl_out <= 1'b0;
    wt(n);
    scl_out <= 1'b1;
  endtask : hold_low
endmodule : cgr_host_model
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the charge and input limit setting block.
// Assumes the host model owns SCL and drives data through a pull-up wire.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cgr_pkg::*;
  // ****
  // Bench
  // ****
  localparam logic [16:0] TICK = 17'h0000a;
  logic       sys_clk, reset_n, scl, sda_h, sda, under, over, vok, vwr, sda_oe, en, tmo, sda_o;
  logic [5:0] cc, ic;
  int         n_fail, n_tests, cyc;

  always #4 sys_clk = ~sys_clk;
  // Open drain: low if either side pulls
  assign sda = sda_h & ~sda_oe;

  cgr_regs #(.TICK_CYC(TICK)) i_cgr_regs (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .scl_in(scl),
    .sda_in(sda), .batt_under_2v5_in(under), .batt_over_2v7_in(over), .charge_voltage_ok_in(vok),
    .charge_voltage_write_in(vwr), .sda_out(sda_o), .sda_oe_out(sda_oe), .charge_dac_code_out(cc),
    .input_limit_dac_code_out(ic), .charge_enable_out(en), .timeout_out(tmo));
  cgr_host_model #(.ADDR(SLAVE_ADDR)) i_cgr_host_model (.clk_in(sys_clk), .sda_in(sda), .scl_out(scl),
    .sda_out(sda_h));

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    cmp_val({15'h0, got}, {15'h0, exp}, what);
  endtask : cmp_flag
  task automatic wr(input logic [7:0] c, input logic [15:0] w);
    logic ok;
    i_cgr_host_model.write_word(SLAVE_ADDR, c, w, ok);
    cmp_flag(ok, 1'b1, "write ack");
    repeat (3) @(posedge sys_clk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] w);
    logic        ok;
    logic [15:0] v;
    i_cgr_host_model.read_word(c, v, ok);
    cmp_flag(ok, 1'b1, "read ack");
    cmp_val(v, w, "read word");
  endtask : rd_chk
  task automatic test_reset();
    cmp_val({10'h0, ic}, 16'h0001, "input code");
    cmp_val({10'h0, cc}, 16'h0000, "charge code");
    cmp_flag(sda_o, 1'b0, "data drive level");
    rd_chk(CMD_CHARGE, 16'h0000);
    rd_chk(CMD_INLIMIT, 16'h0080);
  endtask : test_reset
  task automatic test_codes();
    logic [7:0]  k [11] = '{8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14, 8'h14};
    logic [15:0] w [11] = '{16'h007f, 16'h0100, 16'h157e, 16'h1580, 16'hffff,
                            16'h0100, 16'h0000, 16'h007f, 16'h0080, 16'h1f80, 16'h2080};
    logic [5:0]  c [11] = '{6'h00, 6'h02, 6'h2a, 6'h2a, 6'h2a, 6'h02, 6'h00, 6'h00, 6'h01, 6'h3f, 6'h3f};
    for (int i = 0; i < 11; i++)
    begin
      wr(k[i], w[i]);
      cmp_val({10'h0, (k[i] == CMD_CHARGE) ? cc : ic}, {10'h0, c[i]}, "code");
      if (k[i] == CMD_CHARGE) cmp_flag(en, w[i] > 16'h007f, "enable");
      rd_chk(k[i], w[i]);
    end
  endtask : test_codes
  task automatic test_fold();
    wr(CMD_CHARGE, 16'h0800);
    under <= 1'b1;
    over <= 1'b0;
    repeat (5) @(posedge sys_clk);
    cmp_val({10'h0, cc}, 16'h0001, "foldback");
    under <= 1'b0;
    repeat (5) @(posedge sys_clk);
    cmp_val({10'h0, cc}, 16'h0001, "hysteresis");
    rd_chk(CMD_CHARGE, 16'h0800);
    over <= 1'b1;
    repeat (5) @(posedge sys_clk);
    cmp_val({10'h0, cc}, 16'h0010, "resume");
  endtask : test_fold
  task automatic test_refuse();
    logic ok;
    i_cgr_host_model.write_word(7'h0a, CMD_CHARGE, 16'h0080, ok);
    cmp_flag(ok, 1'b0, "foreign address");
    i_cgr_host_model.write_word(SLAVE_ADDR, 8'h15, 16'h0080, ok);
    cmp_flag(ok, 1'b0, "unmapped command");
    rd_chk(CMD_CHARGE, 16'h0800);
  endtask : test_refuse
  task automatic test_timeout();
    i_cgr_host_model.hold_low(200);
    repeat (4) @(posedge sys_clk);
    cmp_flag(tmo, 1'b0, "early timeout");
    i_cgr_host_model.hold_low(300);
    repeat (4) @(posedge sys_clk);
    cmp_flag(tmo, 1'b1, "timeout");
    cmp_flag(en, 1'b0, "enable in timeout");
    vwr <= 1'b1;
    @(posedge sys_clk);
    vwr <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmp_flag(en, 1'b1, "reenable");
    vok <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmp_flag(en, 1'b0, "no voltage");
  endtask : test_timeout
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Whole run is about 12000 cycles; two and a half times that means a hang
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      final_report();
    end
  end

  initial
  begin
    {sys_clk, reset_n, under, vwr} = 4'h0;
    {over, vok} = 2'h3;
    n_fail = 0;
    n_tests = 0;
    cyc = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    test_reset();
    test_codes();
    test_fold();
    test_refuse();
    test_timeout();
    final_report();
  end
endmodule : tb
`default_nettype wire
